//--- edt_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module edt_pin_model (
	input wire logic clk_sys,
	input wire logic run_events,
	input wire logic pin_out,
	input wire logic pin_oe_n,
	output logic pin_in
);
	logic [1:0] div_reg = 2'h0;
	logic src_reg = 1'b1;
	always_ff @(posedge clk_sys)
	begin
		div_reg <= div_reg + 2'h1;
		if (div_reg == 2'h3)
			src_reg <= run_events ? ~src_reg : 1'b1;
	end
	// Released line follows the event source, returning to the pull-up level once events stop
	assign pin_in = pin_oe_n ? src_reg : pin_out;
endmodule : edt_pin_model
`default_nettype wire

//--- edt_pkg.sv
package edt_pkg;
	localparam logic [1:0] ADDR_STATUS_CONTROL = 2'h0;
	localparam logic [1:0] ADDR_COUNT = 2'h1;
	localparam logic [1:0] ADDR_PRESCALER = 2'h2;
	localparam int BIT_ZERO_FLAG = 7;
	localparam int BIT_IRQ_ENABLE = 6;
	localparam int BIT_DIRECTION = 5;
	localparam int BIT_OUT_LEVEL = 4;
	localparam int BIT_RUN = 3;
	localparam logic [7:0] COUNT_RESET = 8'hff;
	localparam logic [6:0] PRESC_RESET = 7'h7f;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int INT_DIV = 12;
	localparam logic [3:0] INT_DIV_LAST = 4'(INT_DIV - 1);

	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} edt_bus_t;
endpackage : edt_pkg

//--- edt_timer.sv
`timescale 1ns/1ps
`default_nettype none
module edt_timer (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire edt_pkg::edt_bus_t bus,
	output logic [7:0] rdata,
	input wire logic stop_mode,
	input wire logic wait_mode,
	input wire logic timer_pin_in,
	output logic timer_pin_out,
	output logic timer_pin_oe_n,
	output logic timer_irq,
	output logic wake_req
);
	logic [7:0] count_value_reg;
	logic [6:0] presc_reg;
	logic zero_flag_reg;
	logic zero_irq_enable_reg;
	logic pin_direction_select_reg;
	logic pin_output_level_reg;
	logic prescale_run_reg;
	logic [2:0] prescale_select_reg;
	logic pin_latch_reg;
	logic [3:0] div12_reg;
	logic sync1_reg;
	logic sync2_reg;
	logic sync3_reg;
	logic zero_flag_prev_reg;
	logic event_mode;
	logic presc_tick;
	logic count_tick;
	logic [6:0] presc_next;
	logic wr_ctrl;
	logic wr_count;
	logic wr_presc;
	logic underflow;
	logic [7:0] ctrl_view;

	assign wr_ctrl = bus.wr && bus.addr == edt_pkg::ADDR_STATUS_CONTROL;
	assign wr_count = bus.wr && bus.addr == edt_pkg::ADDR_COUNT;
	assign wr_presc = bus.wr && bus.addr == edt_pkg::ADDR_PRESCALER;
	assign event_mode = !pin_direction_select_reg && !pin_output_level_reg;

	// Pin synchroniser; only sync2 and sync3 feed the edge detect
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			// Reset to the pulled-up idle level, so release brings no false edge
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
			sync3_reg <= 1'b1;
		end
		else
		begin
			sync1_reg <= timer_pin_in;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// Internal divide-by-12 stands still in stop, when the core clock is gone
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			div12_reg <= 4'h0;
		else if (!stop_mode)
		begin
			if (div12_reg == edt_pkg::INT_DIV_LAST)
				div12_reg <= 4'h0;
			else
				div12_reg <= div12_reg + 4'h1;
		end
	end

	// All non-event modes, output included, use the internal clock
	always_comb
	begin
		if (event_mode)
			presc_tick = sync2_reg && !sync3_reg;
		else
			presc_tick = !stop_mode && div12_reg == edt_pkg::INT_DIV_LAST;
		presc_tick = presc_tick && prescale_run_reg;
	end

	assign presc_next = (presc_reg == 7'h00) ? edt_pkg::PRESC_RESET : presc_reg - 7'h1;

	// Tap n toggles once every 2^n prescaler ticks: select 0 passes every tick
	always_comb
	begin
		if (prescale_select_reg == 3'h0)
			count_tick = presc_tick;
		else
			count_tick = presc_tick && (presc_reg[prescale_select_reg - 3'h1 -: 1] == 1'b0)
				&& (presc_next[prescale_select_reg - 3'h1] == 1'b1);
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			presc_reg <= edt_pkg::PRESC_RESET;
		else if (!prescale_run_reg)
			presc_reg <= edt_pkg::PRESC_RESET;
		else if (wr_presc)
			presc_reg <= bus.wdata[6:0];
		else if (presc_tick)
			presc_reg <= presc_next;
	end

	assign underflow = count_tick && count_value_reg == 8'h01;

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			count_value_reg <= edt_pkg::COUNT_RESET;
		else if (wr_count)
			count_value_reg <= bus.wdata;
		else if (count_tick)
		begin
			if (count_value_reg == 8'h00)
				count_value_reg <= edt_pkg::COUNT_RESET;
			else
				count_value_reg <= count_value_reg - 8'h01;
		end
	end

	// Hardware sets win over a software clear in the same cycle
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			zero_flag_reg <= 1'b0;
		else if ((underflow && !wr_count) || (wr_count && bus.wdata == 8'h00))
			zero_flag_reg <= 1'b1;
		else if (wr_ctrl)
			zero_flag_reg <= bus.wdata[edt_pkg::BIT_ZERO_FLAG];
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			zero_irq_enable_reg <= 1'b0;
			pin_direction_select_reg <= 1'b0;
			pin_output_level_reg <= 1'b0;
			prescale_run_reg <= 1'b0;
			prescale_select_reg <= 3'h0;
		end
		else if (wr_ctrl)
		begin
			zero_irq_enable_reg <= bus.wdata[edt_pkg::BIT_IRQ_ENABLE];
			pin_direction_select_reg <= bus.wdata[edt_pkg::BIT_DIRECTION];
			pin_output_level_reg <= bus.wdata[edt_pkg::BIT_OUT_LEVEL];
			prescale_run_reg <= bus.wdata[edt_pkg::BIT_RUN];
			prescale_select_reg <= bus.wdata[2:0];
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			zero_flag_prev_reg <= 1'b0;
			pin_latch_reg <= 1'b0;
		end
		else
		begin
			zero_flag_prev_reg <= zero_flag_reg;
			if (zero_flag_reg && !zero_flag_prev_reg)
				pin_latch_reg <= pin_output_level_reg;
		end
	end

	assign timer_pin_out = pin_latch_reg;
	assign timer_pin_oe_n = !pin_direction_select_reg;
	// Wait feeds only wake_req, so timing is untouched by it
	assign timer_irq = zero_flag_reg && zero_irq_enable_reg;
	assign wake_req = timer_irq && (wait_mode || stop_mode);

	assign ctrl_view = {zero_flag_reg, zero_irq_enable_reg, pin_direction_select_reg,
		pin_output_level_reg, prescale_run_reg, prescale_select_reg};

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			rdata <= 8'h00;
		else if (bus.rd && bus.addr == edt_pkg::ADDR_STATUS_CONTROL)
			rdata <= ctrl_view;
		else if (bus.rd && bus.addr == edt_pkg::ADDR_COUNT)
			rdata <= count_value_reg;
		else if (bus.rd && bus.addr == edt_pkg::ADDR_PRESCALER)
			rdata <= {1'b0, presc_reg};
		else
			rdata <= 8'h00;
	end

	a_write_sets_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wr_count && bus.wdata == 8'h00 |=> zero_flag_reg)
		else $error("zero write did not set flag");
	a_write_wins: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wr_count && bus.wdata != 8'h00 && !zero_flag_reg && !wr_ctrl |=> !zero_flag_reg)
		else $error("write lost to decrement");
	a_irq_level: assert property (@(posedge clk_sys) disable iff (sys_rst)
		timer_irq == (zero_flag_reg && zero_irq_enable_reg))
		else $error("irq level wrong");
	a_flag_sticky: assert property (@(posedge clk_sys) disable iff (sys_rst)
		zero_flag_reg && !wr_ctrl |=> zero_flag_reg)
		else $error("flag cleared by hardware");
	a_frozen_stop: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!prescale_run_reg |=> presc_reg == edt_pkg::PRESC_RESET)
		else $error("prescaler not held");
	a_count_reload: assert property (@(posedge clk_sys) disable iff (sys_rst)
		count_tick && count_value_reg == 8'h00 && !wr_count |=> count_value_reg == 8'hff)
		else $error("no reload");
	a_stop_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
		stop_mode && !event_mode && !bus.wr |=> $stable(count_value_reg))
		else $error("counter moved in stop");
	a_pin_drive: assert property (@(posedge clk_sys) disable iff (sys_rst)
		pin_direction_select_reg |-> !timer_pin_oe_n && timer_pin_out == pin_latch_reg)
		else $error("pin not driven");
	a_pin_latch: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$rose(zero_flag_reg) |=> timer_pin_out == $past(pin_output_level_reg))
		else $error("level not latched");

	// Cycles since the last internal prescaler tick; only trusted after one
	// clean tick, as stop, event mode or a halted run leave the divider phase open.
	// Kept beside the checks rather than in the datapath, so it costs no timing.
	logic [3:0] tick_gap_reg;
	logic tick_gap_valid_reg;

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tick_gap_reg <= 4'h0;
			tick_gap_valid_reg <= 1'b0;
		end
		else if (event_mode || stop_mode || !prescale_run_reg)
		begin
			tick_gap_reg <= 4'h0;
			tick_gap_valid_reg <= 1'b0;
		end
		else if (presc_tick)
		begin
			tick_gap_reg <= 4'h0;
			tick_gap_valid_reg <= 1'b1;
		end
		else if (tick_gap_reg != 4'hf)
			tick_gap_reg <= tick_gap_reg + 4'h1;
	end

	// Pin edge as it stands at the pin, before any synchroniser stage
	sequence s_pin_rise;
		!timer_pin_in ##1 timer_pin_in;
	endsequence : s_pin_rise

	sequence s_flag_rise;
		!zero_flag_reg ##1 zero_flag_reg;
	endsequence : s_flag_rise

	// The flag rises only from an underflow, a zero write or a software set
	a_flag_no_cause: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!zero_flag_reg && !underflow && !(wr_count && bus.wdata == 8'h00)
		&& !(wr_ctrl && bus.wdata[edt_pkg::BIT_ZERO_FLAG]) |=> !zero_flag_reg)
		else $error("flag set with no cause");

	a_underflow_sets: assert property (@(posedge clk_sys) disable iff (sys_rst)
		underflow && !wr_count |=> zero_flag_reg)
		else $error("underflow did not set flag");

	a_flag_by_ctrl: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wr_ctrl && bus.wdata[edt_pkg::BIT_ZERO_FLAG] |=> zero_flag_reg)
		else $error("software set of flag lost");

	// Counter and prescaler stepping
	a_count_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wr_count |=> count_value_reg == $past(bus.wdata))
		else $error("count write not loaded");

	a_count_step: assert property (@(posedge clk_sys) disable iff (sys_rst)
		count_tick && !wr_count && count_value_reg != 8'h00
		|=> count_value_reg == $past(count_value_reg) - 8'h01)
		else $error("counter did not step by one");

	a_presc_step: assert property (@(posedge clk_sys) disable iff (sys_rst)
		prescale_run_reg && presc_tick && !wr_presc && presc_reg != 7'h00
		|=> presc_reg == $past(presc_reg) - 7'h01)
		else $error("prescaler did not step by one");

	a_presc_reload: assert property (@(posedge clk_sys) disable iff (sys_rst)
		prescale_run_reg && presc_tick && !wr_presc && presc_reg == 7'h00
		|=> presc_reg == edt_pkg::PRESC_RESET)
		else $error("prescaler did not reload");

	a_counter_frozen: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!prescale_run_reg && !wr_count |=> $stable(count_value_reg))
		else $error("counter moved while halted");

	// Stop freezes the internal path; a running prescaler must not move
	a_stop_presc: assert property (@(posedge clk_sys) disable iff (sys_rst)
		stop_mode && !event_mode && prescale_run_reg && !bus.wr |=> $stable(presc_reg))
		else $error("prescaler moved in stop");

	// Tap 0 passes every prescaler tick; tap 1 every second, on bit 0 rising
	a_tap_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
		prescale_select_reg == 3'h0 |-> count_tick == presc_tick)
		else $error("tap zero wrong");

	a_tap_one: assert property (@(posedge clk_sys) disable iff (sys_rst)
		prescale_select_reg == 3'h1 && count_tick |-> !presc_reg[0] && presc_next[0])
		else $error("tap one wrong");

	// Two synchroniser stages put the tick two cycles after the pin rises
	a_event_tick: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_pin_rise ##2 (event_mode && prescale_run_reg) |-> presc_tick)
		else $error("pin edge not counted");

	// Internal ticks stand exactly twelve cycles apart once the phase is known
	a_div_spacing: assert property (@(posedge clk_sys) disable iff (sys_rst)
		presc_tick && !event_mode && tick_gap_valid_reg |-> tick_gap_reg == edt_pkg::INT_DIV_LAST)
		else $error("internal tick spacing wrong");

	// Wait feeds no counting path, so ticks keep their divider phase
	a_wait_neutral: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wait_mode && !stop_mode && !event_mode && prescale_run_reg
		|-> presc_tick == (div12_reg == edt_pkg::INT_DIV_LAST))
		else $error("wait altered ticking");

	// The latch follows one cycle after the flag rises
	a_pin_follow: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_flag_rise ##1 pin_direction_select_reg |-> timer_pin_out == $past(pin_output_level_reg))
		else $error("pin did not follow level");

	a_pin_release: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!pin_direction_select_reg |-> timer_pin_oe_n)
		else $error("pin driven while input");

	// Interrupt and wake are plain levels with no memory of their own
	a_irq_clears: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!zero_irq_enable_reg |-> !timer_irq)
		else $error("irq with enable clear");

	a_wake_level: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wake_req == (timer_irq && (wait_mode || stop_mode)))
		else $error("wake level wrong");
endmodule : edt_timer
`default_nettype wire

//--- edt_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module edt_timer_tb;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	edt_pkg::edt_bus_t bus = '0;
	logic stop_mode = 1'b0;
	logic wait_mode = 1'b0;
	logic run_events = 1'b0;
	logic [7:0] rdata, d, e;
	logic timer_pin_in, timer_pin_out, timer_pin_oe_n, timer_irq, wake_req;
	int num_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	int seed = 32'h0e28;
	int i;
	edt_timer edt_timer_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
		.stop_mode(stop_mode), .wait_mode(wait_mode), .timer_pin_in(timer_pin_in),
		.timer_pin_out(timer_pin_out), .timer_pin_oe_n(timer_pin_oe_n),
		.timer_irq(timer_irq), .wake_req(wake_req));
	edt_pin_model edt_pin_model_inst (.clk_sys(clk_sys), .run_events(run_events),
		.pin_out(timer_pin_out), .pin_oe_n(timer_pin_oe_n), .pin_in(timer_pin_in));
	initial
	begin
		forever #5 clk_sys = ~clk_sys;
	end
	function automatic logic [7:0] ctrl(input logic irq, input logic dir, input logic lvl);
		return {1'b0, irq, dir, lvl, 1'b1, 3'h0};
	endfunction : ctrl
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		bus.addr <= a;
		bus.wdata <= v;
		bus.wr <= 1'b1;
		@(posedge clk_sys);
		bus.wr <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [1:0] a);
		@(posedge clk_sys);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask : rd
	task automatic end_of_test;
		$display("errors=%0d comparisons=%0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			end_of_test();
		end
	end
	initial
	begin
		repeat (20) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(2'h1); check(d, edt_pkg::COUNT_RESET);
		rd(2'h2); check(d, {1'b0, edt_pkg::PRESC_RESET});
		rd(2'h0); check(d, edt_pkg::CTRL_RESET);
		rd(2'h3); check(d, 8'h00);
		for (i = 0; i < 8; i++)
		begin
			e = 8'($random(seed)) | 8'h01;
			wr(2'h1, e);
			rd(2'h1); check(d, e);
		end
		wr(2'h2, 8'h10);
		rd(2'h2); check(d, 8'h7f);
		wr(2'h0, 8'h40);
		wr(2'h1, 8'h00);
		rd(2'h0); check(8'(d[7]), 8'h01);
		check(8'(timer_irq), 8'h01);
		@(posedge clk_sys);
		wait_mode <= 1'b1;
		@(posedge clk_sys);
		#1 check(8'(wake_req), 8'h01);
		wr(2'h0, 8'h40);
		#1 check(8'(timer_irq), 8'h00);
		rd(2'h0); check(8'(d[7]), 8'h00);
		wr(2'h0, 8'hc0);
		#1 check(8'(timer_irq), 8'h01);
		@(posedge clk_sys);
		wait_mode <= 1'b0;
		wr(2'h0, ctrl(1'b0, 1'b1, 1'b1));
		wr(2'h1, 8'h02);
		d = 8'h00;
		for (i = 0; i < 150 && d[7] !== 1'b1; i++)
			rd(2'h0);
		check(8'(d[7]), 8'h01);
		check(8'(i >= 7 && i <= 13), 8'h01);
		check({timer_pin_oe_n, timer_pin_out}, 8'h01);
		repeat (12) @(posedge clk_sys);
		rd(2'h1); check(d, edt_pkg::COUNT_RESET);
		@(posedge clk_sys);
		stop_mode <= 1'b1;
		rd(2'h1);
		e = d;
		repeat (60) @(posedge clk_sys);
		rd(2'h1); check(d, e);
		wr(2'h0, ctrl(1'b0, 1'b0, 1'b0));
		wr(2'h1, 8'h10);
		run_events <= 1'b1;
		repeat (100) @(posedge clk_sys);
		run_events <= 1'b0;
		rd(2'h1); check(8'(d >= 8'h03 && d <= 8'h05), 8'h01);
		@(posedge clk_sys);
		stop_mode <= 1'b0;
		wr(2'h0, ctrl(1'b0, 1'b1, 1'b0) | 8'h01);
		wr(2'h1, 8'h02);
		d = 8'h00;
		for (i = 0; i < 150 && d[7] !== 1'b1; i++)
			rd(2'h0);
		check(8'(i >= 13 && i <= 25), 8'h01);
		check({timer_pin_oe_n, timer_pin_out}, 8'h00);
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(2'h1); check(d, edt_pkg::COUNT_RESET);
		check({timer_pin_oe_n, timer_pin_out}, 8'h02);
		end_of_test();
	end
endmodule : edt_timer_tb
`default_nettype wire
